// File: design/fsrb_pkg.sv
package fsrb_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_CTRL    = 6'h01;
	localparam logic [5:0] IDX_SUMMARY = 6'h02;
	localparam logic [5:0] IDX_NEG     = 6'h04;
	localparam logic [5:0] IDX_SERIAL  = 6'h05;
	localparam logic [5:0] IDX_COUNT   = 6'h06;
	localparam logic [5:0] IDX_MODE    = 6'h07;

	// Serial-link fault register fields
	localparam int SER_STARTUP_BIT = 2;
	localparam int SER_CS_BIT      = 1;
	localparam int SER_FRAME_BIT   = 0;

	// Mode-pin capture fields
	localparam int MODE_CODING_LSB = 4;
	localparam int MODE_WORD_LSB   = 2;
	localparam int MODE_IF_LSB     = 0;

	// Summary register fields
	localparam int SUM_SERIAL_BIT = 5;
	localparam int SUM_INPUT_BIT  = 4;
	localparam int SUM_CHECK_BIT  = 0;

	// Control register fields and reset value
	localparam int         CTRL_FRAME_EN_BIT = 0;
	localparam int         CTRL_CS_EN_BIT    = 1;
	localparam logic [1:0] CTRL_RESET        = 2'h3;

	// Counter and register reset values
	localparam logic [7:0]  COUNT_MAX   = 8'hFF;
	localparam logic [7:0]  COUNT_RESET = 8'h00;
	localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

endpackage : fsrb_pkg

// File: design/fsrb_bank.sv
`timescale 1ns/1ps
module fsrb_bank
	import fsrb_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic [3:0]        neg_over,
	input  wire logic              pos_fault_any,
	input  wire logic              pos_fault_read,
	input  wire logic              startup_error,
	input  wire logic              cs_edge_fault,
	input  wire logic              short_frame,
	input  wire logic              word_error,
	input  wire logic [1:0]        coding_select_pin_state,
	input  wire logic [1:0]        word_size_pin_state,
	input  wire logic [1:0]        interface_mode_pin_state,
	output logic                   input_check_fault,
	output logic                   cmd_discard,
	output logic                   summary_input_fault
);

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic [3:0]  neg;
		logic        startup;
		logic        cs;
		logic        frame;
		logic [7:0]  tally;
		logic [5:0]  mode;
		logic        captured;
		logic        check;
		logic        in_sum;
		logic        neg_seen;
		logic        pos_seen;
		logic [1:0]  ctrl;
		logic        discard;
	} fsrb_state_t;

	fsrb_state_t s;
	fsrb_state_t next_s;
	logic [3:0]  ch_impl;
	logic        access;
	logic        addr_ok;
	logic [5:0]  idx;
	logic        rd_neg;
	logic        rd_serial;
	logic        rd_count;

	// Absent channels are forced to zero for the smaller variant
	genvar ch;
	generate
		for (ch = 0; ch < 4; ch++) begin : g_ch
			assign ch_impl[ch] = (ch < NUM_CH);
		end
	endgenerate

	// Side effects happen on the edge that captures read data, so an
	// event in the same cycle still lands after the clear
	assign access    = psel && penable && !s.pready;
	assign idx       = paddr[7:2];
	assign addr_ok   = (paddr[1:0] == 2'h0) && ((paddr >> 8) == '0);
	assign rd_neg    = access && !pwrite && addr_ok && (idx == IDX_NEG);
	assign rd_serial = access && !pwrite && addr_ok && (idx == IDX_SERIAL);
	assign rd_count  = access && !pwrite && addr_ok && (idx == IDX_COUNT);

	// Next-state logic for bus answer and all flags
	always_comb begin
		next_s = s;
		next_s.pready  = access;
		next_s.pslverr = 1'b0;
		next_s.discard = word_error;
		if (access) begin
			next_s.prdata = RDATA_ZERO;
			if (addr_ok) begin
				unique case (idx)
					IDX_CTRL: begin
						if (pwrite)
							next_s.ctrl = pwdata[1:0];
						else
							next_s.prdata[1:0] = s.ctrl;
					end
					IDX_SUMMARY: begin
						next_s.prdata[SUM_SERIAL_BIT] = s.startup | s.cs | s.frame;
						next_s.prdata[SUM_INPUT_BIT]  = s.in_sum;
						next_s.prdata[SUM_CHECK_BIT]  = s.check;
					end
					IDX_NEG:    next_s.prdata[3:0] = s.neg;
					IDX_SERIAL: next_s.prdata[2:0] = {s.startup, s.cs, s.frame};
					IDX_COUNT:  next_s.prdata[7:0] = s.tally;
					IDX_MODE:   next_s.prdata[5:0] = s.mode;
					default:    next_s.pslverr = 1'b1;
				endcase
			end else begin
				next_s.pslverr = 1'b1;
			end
		end
		// Negative-input flags: sticky, read clears, live input wins
		if (rd_neg)
			next_s.neg = '0;
		next_s.neg = next_s.neg | (neg_over & ch_impl);
		// Startup flag only ever sets; reset stands for power cycling
		if (startup_error)
			next_s.startup = 1'b1;
		// Serial read clears CS, frame and check faults, not startup; a fresh enabled event keeps them set
		if (rd_serial) begin
			next_s.cs    = 1'b0;
			next_s.frame = 1'b0;
			next_s.check = 1'b0;
		end
		if (cs_edge_fault && s.ctrl[CTRL_CS_EN_BIT])
			next_s.cs = 1'b1;
		if (short_frame && s.ctrl[CTRL_FRAME_EN_BIT])
			next_s.frame = 1'b1;
		if (word_error)
			next_s.check = 1'b1;
		// Error tally: clear on read, then count with saturation
		if (rd_count)
			next_s.tally = COUNT_RESET;
		if (word_error && next_s.tally != COUNT_MAX)
			next_s.tally = next_s.tally + 8'h01;
		// Input summary needs both input registers read to clear
		if (rd_neg)
			next_s.neg_seen = 1'b1;
		if (pos_fault_read)
			next_s.pos_seen = 1'b1;
		if (next_s.neg_seen && next_s.pos_seen) begin
			next_s.in_sum   = 1'b0;
			next_s.neg_seen = 1'b0;
			next_s.pos_seen = 1'b0;
		end
		if ((|(neg_over & ch_impl)) || pos_fault_any)
			next_s.in_sum = 1'b1;
		// Pins sampled once on the first edge after reset release
		if (!s.captured) begin
			next_s.captured = 1'b1;
			next_s.mode[MODE_CODING_LSB +: 2] = coding_select_pin_state;
			next_s.mode[MODE_WORD_LSB +: 2]   = word_size_pin_state;
			next_s.mode[MODE_IF_LSB +: 2]     = interface_mode_pin_state;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s      <= '0;
			s.ctrl <= CTRL_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state
	assign pready              = s.pready;
	assign prdata              = s.prdata;
	assign pslverr             = s.pslverr;
	assign input_check_fault   = s.check;
	assign cmd_discard         = s.discard;
	assign summary_input_fault = s.in_sum;

	// Checks
	property p_neg_unimpl;
		@(posedge pclk) disable iff (!presetn)
		(s.neg & ~ch_impl) == 4'h0;
	endproperty
	a_neg_unimpl: assert property (p_neg_unimpl) else $error("absent channel flag set");

	property p_startup_hold;
		@(posedge pclk) disable iff (!presetn)
		s.startup |=> s.startup [*8];
	endproperty
	a_startup_hold: assert property (p_startup_hold) else $error("startup flag cleared");

	property p_cs_set;
		@(posedge pclk) disable iff (!presetn)
		(cs_edge_fault && s.ctrl[CTRL_CS_EN_BIT]) |=> s.cs;
	endproperty
	a_cs_set: assert property (p_cs_set) else $error("cs fault not set");

	property p_frame_clear;
		@(posedge pclk) disable iff (!presetn)
		(rd_serial && !short_frame) |=> !s.frame;
	endproperty
	a_frame_clear: assert property (p_frame_clear) else $error("frame fault not cleared");

	property p_count_sat;
		@(posedge pclk) disable iff (!presetn)
		(s.tally == COUNT_MAX && !rd_count) |=> (s.tally == COUNT_MAX);
	endproperty
	a_count_sat: assert property (p_count_sat) else $error("counter left saturation");

	property p_count_clear;
		@(posedge pclk) disable iff (!presetn)
		(rd_count && !word_error) |=> (s.tally == COUNT_RESET) ##1 (s.prdata[7:0] == $past(s.tally, 2));
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("counter not cleared on read");

	property p_count_inc;
		@(posedge pclk) disable iff (!presetn)
		(word_error && !rd_count && s.tally != COUNT_MAX) |=> (s.tally == $past(s.tally) + 8'h01);
	endproperty
	a_count_inc: assert property (p_count_inc) else $error("counter step wrong");

	property p_mode_hold;
		@(posedge pclk) disable iff (!presetn)
		s.captured |=> $stable(s.mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode capture changed");

	property p_discard;
		@(posedge pclk) disable iff (!presetn)
		word_error |=> (cmd_discard && input_check_fault);
	endproperty
	a_discard: assert property (p_discard) else $error("bad word not flagged");

	property p_mode_read;
		@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && addr_ok && idx == IDX_MODE) |=> (prdata[7:6] == 2'h0) && pready;
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

	// Read data against the state it was taken from, zero bits included
	property p_neg_read;
		@(posedge pclk) disable iff (!presetn)
		rd_neg |=> pready && (prdata[31:4] == 28'h000_0000) && (prdata[3:0] == $past(s.neg));
	endproperty
	a_neg_read: assert property (p_neg_read) else $error("neg read wrong");

	property p_neg_clear;
		@(posedge pclk) disable iff (!presetn)
		(rd_neg && neg_over == 4'h0) |=> (s.neg == 4'h0);
	endproperty
	a_neg_clear: assert property (p_neg_clear) else $error("neg flags kept");

	property p_serial_read;
		@(posedge pclk) disable iff (!presetn)
		rd_serial |=> pready && (prdata[31:3] == 29'h0000_0000)
			&& (prdata[SER_STARTUP_BIT] == $past(s.startup));
	endproperty
	a_serial_read: assert property (p_serial_read) else $error("serial read wrong");

	property p_startup_set;
		@(posedge pclk) disable iff (!presetn)
		startup_error |=> s.startup;
	endproperty
	a_startup_set: assert property (p_startup_set) else $error("startup not set");

	property p_cs_clear;
		@(posedge pclk) disable iff (!presetn)
		(rd_serial && !cs_edge_fault) |=> !s.cs;
	endproperty
	a_cs_clear: assert property (p_cs_clear) else $error("cs fault kept");

	property p_frame_set;
		@(posedge pclk) disable iff (!presetn)
		(short_frame && s.ctrl[CTRL_FRAME_EN_BIT]) |=> s.frame;
	endproperty
	a_frame_set: assert property (p_frame_set) else $error("frame fault not set");

	// Counter: a read must never swallow an error arriving in the same cycle
	property p_cnt_read;
		@(posedge pclk) disable iff (!presetn)
		rd_count |=> pready && (prdata[31:8] == 24'h00_0000) && (prdata[7:0] == $past(s.tally));
	endproperty
	a_cnt_read: assert property (p_cnt_read) else $error("count read wrong");

	property p_cnt_wins;
		@(posedge pclk) disable iff (!presetn)
		(rd_count && word_error) |=> (s.tally == 8'h01);
	endproperty
	a_cnt_wins: assert property (p_cnt_wins) else $error("error lost on read");

	property p_cnt_idle;
		@(posedge pclk) disable iff (!presetn)
		(!word_error && !rd_count) |=> $stable(s.tally);
	endproperty
	a_cnt_idle: assert property (p_cnt_idle) else $error("count moved idle");

	property p_cnt_no_wrap;
		@(posedge pclk) disable iff (!presetn)
		(s.tally == COUNT_MAX) |=> (s.tally != COUNT_RESET) || $past(rd_count);
	endproperty
	a_cnt_no_wrap: assert property (p_cnt_no_wrap) else $error("count wrapped");

	property p_mode_coding;
		@(posedge pclk) disable iff (!presetn)
		$rose(s.captured) |-> (s.mode[MODE_CODING_LSB +: 2] == $past(coding_select_pin_state));
	endproperty
	a_mode_coding: assert property (p_mode_coding) else $error("coding pin lost");

	property p_mode_word;
		@(posedge pclk) disable iff (!presetn)
		$rose(s.captured) |-> (s.mode[MODE_WORD_LSB +: 2] == $past(word_size_pin_state));
	endproperty
	a_mode_word: assert property (p_mode_word) else $error("word pin lost");

	property p_mode_if;
		@(posedge pclk) disable iff (!presetn)
		$rose(s.captured) |-> (s.mode[MODE_IF_LSB +: 2] == $past(interface_mode_pin_state));
	endproperty
	a_mode_if: assert property (p_mode_if) else $error("interface pin lost");

	property p_sum_serial;
		@(posedge pclk) disable iff (!presetn)
		(access && !pwrite && addr_ok && idx == IDX_SUMMARY)
			|=> (prdata[SUM_SERIAL_BIT] == ($past(s.startup) || $past(s.cs) || $past(s.frame)));
	endproperty
	a_sum_serial: assert property (p_sum_serial) else $error("serial summary wrong");

	property p_insum_set;
		@(posedge pclk) disable iff (!presetn)
		pos_fault_any |=> summary_input_fault;
	endproperty
	a_insum_set: assert property (p_insum_set) else $error("input summary not set");

	property p_check_clear;
		@(posedge pclk) disable iff (!presetn)
		(rd_serial && !word_error) |=> !s.check;
	endproperty
	a_check_clear: assert property (p_check_clear) else $error("check fault kept");

	c_saturate: cover property (@(posedge pclk) disable iff (!presetn) s.tally == COUNT_MAX);
	c_cs_clear: cover property (@(posedge pclk) disable iff (!presetn) s.cs && rd_serial);
	c_insum:    cover property (@(posedge pclk) disable iff (!presetn) $fell(s.in_sum));
	c_gated:    cover property (@(posedge pclk) disable iff (!presetn) !s.ctrl[CTRL_CS_EN_BIT]);
	c_recap:    cover property (@(posedge pclk) disable iff (!presetn) $rose(s.captured));

endmodule : fsrb_bank

// File: verification/fsrb_link_model.sv
`timescale 1ns/1ps
// Far-side link monitor: turns bench requests into fault events one clock later
module fsrb_link_model (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [3:0] fire,
	output logic            startup_error,
	output logic            cs_edge_fault,
	output logic            short_frame,
	output logic            word_error
);
	// Registered, so each event follows its request one clock later and lasts as long as the request is held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{startup_error, cs_edge_fault, short_frame, word_error} <= 4'h0;
		end else begin
			{startup_error, cs_edge_fault, short_frame, word_error} <= fire;
		end
	end
endmodule : fsrb_link_model

// File: verification/fault_status_register_bank_tb.sv
`timescale 1ns/1ps
module fault_status_register_bank_tb;
	import fsrb_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, startup_error, cs_edge_fault, short_frame, word_error;
	logic [3:0]  neg_over = 4'h0, fire = 4'h0;
	logic [1:0]  coding_select_pin_state = 2'h2, word_size_pin_state = 2'h1;
	logic [1:0]  interface_mode_pin_state = 2'h0;
	logic        pos_fault_any = 0, pos_fault_read = 0, input_check_fault, cmd_discard;
	logic        summary_input_fault;
	int          fail_count = 0, total_checks = 0;

	// Free-running bus clock
	always #2 pclk = ~pclk;

	fsrb_bank #(.NUM_CH(4), .ADDR_W(8)) i_fsrb_bank (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .neg_over,
		.pos_fault_any, .pos_fault_read, .startup_error, .cs_edge_fault,
		.short_frame, .word_error, .coding_select_pin_state, .word_size_pin_state,
		.interface_mode_pin_state, .input_check_fault, .cmd_discard,
		.summary_input_fault);

	fsrb_link_model i_fsrb_link_model (.pclk, .presetn, .fire, .startup_error,
		.cs_edge_fault, .short_frame, .word_error);

	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude

	task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen at an edge
	task apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// No local limit; only the watchdog ends a stuck transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0000_0000);
		chk(name, rd, exp);
	endtask : rchk

	// Gapped events, so a counter sees each one separately
	task pulse(input int b, input int n);
		repeat (n) begin
			fire <= 4'(1 << b);
			@(posedge pclk);
			fire <= 4'h0;
			@(posedge pclk);
		end
	endtask : pulse

	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 4; i < 7; i++) begin
			rchk("reset value", 6'(i), 32'h0000_0000);
		end
		rchk("mode pins", IDX_MODE, 32'h0000_0024);
		coding_select_pin_state  <= 2'h1;
		word_size_pin_state      <= 2'h2;
		interface_mode_pin_state <= 2'h3;
		rchk("mode held", IDX_MODE, 32'h0000_0024);
		// Input summary must outlive the first of the two register reads
		neg_over      <= 4'hA;
		pos_fault_any <= 1'b1;
		@(posedge pclk);
		neg_over      <= 4'h0;
		pos_fault_any <= 1'b0;
		@(posedge pclk);
		chk("in sum set", 32'(summary_input_fault), 32'h0000_0001);
		rchk("neg flags", IDX_NEG, 32'h0000_000A);
		chk("in sum kept", 32'(summary_input_fault), 32'h0000_0001);
		pos_fault_read <= 1'b1;
		@(posedge pclk);
		pos_fault_read <= 1'b0;
		@(posedge pclk);
		chk("in sum cleared", 32'(summary_input_fault), 32'h0000_0000);
		rchk("neg cleared", IDX_NEG, 32'h0000_0000);
		pulse(3, 1);
		pulse(2, 1);
		pulse(1, 1);
		rchk("serial all", IDX_SERIAL, 32'h0000_0007);
		rchk("serial summary", IDX_SUMMARY, 32'h0000_0020);
		rchk("serial sticky", IDX_SERIAL, 32'h0000_0004);
		// Link checks off: fresh CS and frame events must leave no trace
		apb(1'b1, IDX_CTRL, 32'h0000_0000);
		rchk("checks off", IDX_CTRL, 32'h0000_0000);
		pulse(2, 1);
		pulse(1, 1);
		rchk("serial gated", IDX_SERIAL, 32'h0000_0004);
		apb(1'b1, IDX_CTRL, 32'h0000_0003);
		pulse(0, 3);
		@(posedge pclk);
		chk("discard", 32'(cmd_discard), 32'h0000_0001);
		chk("check fault", 32'(input_check_fault), 32'h0000_0001);
		rchk("check summary", IDX_SUMMARY, 32'h0000_0021);
		rchk("serial again", IDX_SERIAL, 32'h0000_0004);
		chk("check cleared", 32'(input_check_fault), 32'h0000_0000);
		apb(1'b1, IDX_COUNT, 32'h0000_0055);
		rchk("count", IDX_COUNT, 32'h0000_0003);
		rchk("count cleared", IDX_COUNT, 32'h0000_0000);
		pulse(0, 260);
		rchk("count saturated", IDX_COUNT, {24'h00_0000, COUNT_MAX});
		apb(1'b0, 6'h09, 32'h0000_0000);
		chk("unmapped error", {31'h0000_0000, err}, 32'h0000_0001);
		// Second reset stands for a power cycle: sticky state and pins start over
		pulse(0, 2);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rchk("startup after reset", IDX_SERIAL, 32'h0000_0000);
		rchk("count after reset", IDX_COUNT, 32'h0000_0000);
		rchk("mode recaptured", IDX_MODE, 32'h0000_001B);
		conclude();
	end

	// Hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		#80000;
		fail_count++;
		conclude();
	end
endmodule : fault_status_register_bank_tb
